// *** design/rsp_pkg.sv ***
package rsp_pkg;
    // Register byte offsets
    localparam logic [4:0] ADDR_CFG = 5'h00;
    localparam logic [4:0] ADDR_TXDATA = 5'h04;
    localparam logic [4:0] ADDR_RXDATA = 5'h08;
    localparam logic [4:0] ADDR_STATUS = 5'h0c;
    localparam logic [4:0] ADDR_CTRL = 5'h10;

    // Configuration register fields
    localparam int CFG_SERIAL_BIT = 0;
    localparam int CFG_ADDR_LSB = 1;
    localparam int CFG_ADDR_MSB = 5;
    localparam int CFG_BAUD_LSB = 6;
    localparam int CFG_BAUD_MSB = 8;
    localparam int CFG_PAR_LSB = 9;
    localparam int CFG_PAR_MSB = 10;

    // Status register fields
    localparam int ST_RXVALID = 8;
    localparam int ST_TXFULL = 9;
    localparam int ST_TXBUSY = 10;
    localparam int ST_DTR = 11;
    localparam int ST_DSR = 12;
    localparam int ST_FRAMEERR = 13;
    localparam int ST_PARERR = 14;
    localparam int ST_OVERRUN = 15;
    localparam int ST_NEWLINE = 16;
    localparam int ST_RESPPEND = 17;

    // Control register fields
    localparam int CTRL_RESP_PEND = 0;
    localparam int CTRL_RESP_LAST = 1;

    // Parity modes, each also fixing the data width
    typedef enum logic [1:0] {
        RSP_PAR_NONE = 2'b00,
        RSP_PAR_EVEN = 2'b01,
        RSP_PAR_ODD = 2'b10
    } rsp_parity_t;

    // Factory defaults and legal ranges
    localparam logic DEF_SERIAL = 1'b0;
    localparam logic [4:0] DEF_BUS_ADDR = 5'h05;
    localparam logic [4:0] BUS_ADDR_MAX = 5'h1e;
    localparam logic [2:0] DEF_BAUD_SEL = 3'h5;
    localparam logic [2:0] BAUD_SEL_MAX = 3'h5;
    localparam rsp_parity_t DEF_PARITY = RSP_PAR_NONE;

    // Bit rates, indexed by the baud select
    localparam int NUM_RATES = 6;
    localparam int BAUD_RATE [NUM_RATES] = '{300, 600, 1200, 2400, 4800, 9600};
    localparam int DIV_W = 20;

    // Frame shape
    localparam logic [3:0] DATA_BITS_NOPAR = 4'h8;
    localparam logic [3:0] DATA_BITS_PAR = 4'h7;

    // Receive buffer
    localparam int RX_DEPTH = 128;
    localparam int RX_PTR_W = 7;
    localparam logic [7:0] RX_HIGH_WATER = 8'h64;
    localparam logic [7:0] NEWLINE_CHAR = 8'h0a;

    // Serial state machines
    typedef enum logic [2:0] {
        RSP_IDLE = 3'b000,
        RSP_START = 3'b001,
        RSP_DATA = 3'b010,
        RSP_PARITY = 3'b011,
        RSP_STOP1 = 3'b100,
        RSP_STOP2 = 3'b101
    } rsp_state_t;
endpackage : rsp_pkg

// *** design/rsp_bit_timer.sv ***
`timescale 1ns/1ps
module rsp_bit_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic [rsp_pkg::DIV_W-1:0] divisor,
    input wire logic restart,
    // Ticks
    output logic midTick,
    output logic endTick
);
    import rsp_pkg::*;

    logic [DIV_W-1:0] count;

    // Free-running bit period counter, realigned on restart
    always_ff @(posedge clk) begin
        if (!rst_n || restart) begin
            count <= '0;
        end else if (count >= divisor - 20'h1) begin
            count <= '0;
        end else begin
            count <= count + 20'h1;
        end
    end

    // Mid tick samples the bit centre, end tick closes a bit
    always_comb begin
        midTick = !restart && (count == (divisor >> 1));
        endTick = !restart && (count >= divisor - 20'h1);
    end
endmodule : rsp_bit_timer

// *** design/rsp_serial_port.sv ***
// Function
// [R1] Exactly one remote interface enabled
// [R2] Parallel bus selected by default
// [R3] Interface select survives remote reset
// [R4] Bus address accepted only 0 to 30
// [R5] Bus address defaults to 5
// [R6] Bus address survives remote reset
// [R7] Six bit rates set bit timing
// [R8] Bit rate defaults to 9600
// [R9] Bit rate survives remote reset
// [R10] Parity mode fixes data width
// [R11] Default no parity, 8 data bits
// [R12] Parity setting survives remote reset
// [R13] One start bit per character
// [R14] Two stop bits per character
// [R15] Start, data, parity, stop order
// [R16] Terminal role: DTR out, DSR in
// [R17] Settings change only from local side
// [R18] DTR false near 100 buffered characters
// [R19] Host stops within 10 characters
// [R20] Send only while DSR true
// [R21] DTR false until response sent
// [R22] Parity even or odd, LSB first
// [R23] Receive centre sampling, stop check
`timescale 1ns/1ps
module rsp_serial_port #(
    parameter int CLK_HZ = 125000000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Local register bus
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Remote clear from command layer
    input wire logic remoteClear,
    // Interface selection
    output logic busEnable,
    output logic serialEnable,
    output logic [4:0] busAddrOut,
    // Serial pins
    input wire logic rxd,
    output logic txd,
    output logic dtr,
    input wire logic dsr
);
    import rsp_pkg::*;

    logic ifaceSerial;
    logic [4:0] busAddr;
    logic [2:0] baudSel;
    rsp_parity_t parity;
    logic [DIV_W-1:0] divisor;
    logic [3:0] dataBits;
    logic accept;
    logic cfgWe;
    logic rxdMeta, rxdSync, rxdLast, dsrMeta, dsrSync;
    logic [7:0] txHold;
    logic txFull;
    logic txLoad;
    rsp_state_t txState;
    logic [7:0] txShift;
    logic [3:0] txBitCnt;
    logic txParAcc;
    logic txMid, txEnd;
    rsp_state_t rxState;
    logic [7:0] rxShift;
    logic [3:0] rxBitCnt;
    logic rxParAcc;
    logic rxStartEdge, rxMid, rxEnd;
    logic [7:0] rxByte;
    logic rxPush, rxPop;
    logic [7:0] rxMem [RX_DEPTH];
    logic [RX_PTR_W-1:0] rxWrPtr, rxRdPtr;
    logic [7:0] rxCount;
    logic frameErr, parErr, overrun;
    logic newlineSeen, respPending, respLast, respDone;

    // Divisor per bit rate, folded to constants by the loop
    // [R7] rate to divisor
    always_comb begin
        divisor = 20'(CLK_HZ / BAUD_RATE[NUM_RATES-1]);
        for (int i = 0; i < NUM_RATES; i++) begin
            if (baudSel == 3'(i)) begin
                divisor = 20'(CLK_HZ / BAUD_RATE[i]);
            end
        end
    end

    // [R10] parity sets data width
    assign dataBits = (parity == RSP_PAR_NONE) ? DATA_BITS_NOPAR : DATA_BITS_PAR;

    // Pins from the host cross two flip-flops first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxdMeta <= 1'b1;
            rxdSync <= 1'b1;
            rxdLast <= 1'b1;
            dsrMeta <= 1'b0;
            dsrSync <= 1'b0;
        end else begin
            rxdMeta <= rxd;
            rxdSync <= rxdMeta;
            rxdLast <= rxdSync;
            dsrMeta <= dsr;
            dsrSync <= dsrMeta;
        end
    end

    // Bus handshake; a full transmit holding register stalls the write
    assign accept = (read || write) && waitrequest
        && !(write && address == ADDR_TXDATA && txFull);
    assign cfgWe = accept && write && address == ADDR_CFG && byteenable[1:0] == 2'b11;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !accept;
        end
    end

    // Settings held as if in nonvolatile store; remote clear never touches them
    // [R3] [R6] [R9] [R12] survive remote clear
    // [R17] local bus only writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // [R2] [R5] [R8] [R11] factory defaults
            ifaceSerial <= DEF_SERIAL;
            busAddr <= DEF_BUS_ADDR;
            baudSel <= DEF_BAUD_SEL;
            parity <= DEF_PARITY;
        end else if (cfgWe) begin
            ifaceSerial <= writedata[CFG_SERIAL_BIT];
            // [R4] reject out of range
            if (writedata[CFG_ADDR_MSB:CFG_ADDR_LSB] <= BUS_ADDR_MAX) begin
                busAddr <= writedata[CFG_ADDR_MSB:CFG_ADDR_LSB];
            end
            // [R7] only six rates
            if (writedata[CFG_BAUD_MSB:CFG_BAUD_LSB] <= BAUD_SEL_MAX) begin
                baudSel <= writedata[CFG_BAUD_MSB:CFG_BAUD_LSB];
            end
            if (writedata[CFG_PAR_MSB:CFG_PAR_LSB] != 2'b11) begin
                parity <= rsp_parity_t'(writedata[CFG_PAR_MSB:CFG_PAR_LSB]);
            end
        end
    end

    // [R1] one interface at a time
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busEnable <= 1'b1;
            serialEnable <= 1'b0;
            busAddrOut <= DEF_BUS_ADDR;
        end else begin
            busEnable <= !ifaceSerial;
            serialEnable <= ifaceSerial;
            busAddrOut <= busAddr;
        end
    end

    // Read data and side effects of a read
    assign rxPop = accept && read && address == ADDR_RXDATA && rxCount != 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readdata <= 32'h0;
        end else if (accept && read) begin
            unique case (address)
                ADDR_CFG: readdata <= {21'h0, parity, baudSel, busAddr, ifaceSerial};
                ADDR_RXDATA: readdata <= {23'h0, rxCount != 8'h00, rxMem[rxRdPtr]};
                ADDR_STATUS: readdata <= {14'h0, respPending, newlineSeen, overrun, parErr,
                    frameErr, dsrSync, dtr, txState != RSP_IDLE, txFull, rxCount != 8'h00,
                    rxCount};
                ADDR_CTRL: readdata <= {30'h0, respLast, respPending};
                default: readdata <= 32'h0;
            endcase
        end
    end

    // Transmit holding register; remote clear drops pending output
    // [R20] start only with DSR true
    assign txLoad = txState == RSP_IDLE && txFull && dsrSync && ifaceSerial;

    always_ff @(posedge clk) begin
        if (!rst_n || remoteClear) begin
            txFull <= 1'b0;
            txHold <= 8'h00;
        end else if (accept && write && address == ADDR_TXDATA && byteenable[0]) begin
            txFull <= 1'b1;
            txHold <= writedata[7:0];
        end else if (txLoad) begin
            txFull <= 1'b0;
        end
    end

    rsp_bit_timer txTimer (
        .clk(clk),
        .rst_n(rst_n),
        .divisor(divisor),
        .restart(txLoad),
        .midTick(txMid),
        .endTick(txEnd)
    );

    // Transmit frame sequencer
    // [R15] frame order
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txState <= RSP_IDLE;
            txd <= 1'b1;
            txShift <= 8'h00;
            txBitCnt <= 4'h0;
            txParAcc <= 1'b0;
        end else begin
            unique case (txState)
                RSP_IDLE: begin
                    txd <= 1'b1;
                    if (txLoad) begin
                        // [R13] single start bit
                        txd <= 1'b0;
                        txShift <= txHold;
                        txParAcc <= parity == RSP_PAR_ODD;
                        txState <= RSP_START;
                    end
                end
                RSP_START: begin
                    if (txEnd) begin
                        // [R22] least significant first
                        txd <= txShift[0];
                        txParAcc <= txParAcc ^ txShift[0];
                        txShift <= txShift >> 1;
                        txBitCnt <= 4'h1;
                        txState <= RSP_DATA;
                    end
                end
                RSP_DATA: begin
                    if (txEnd && txBitCnt == dataBits) begin
                        txd <= (parity == RSP_PAR_NONE) ? 1'b1 : txParAcc;
                        txState <= (parity == RSP_PAR_NONE) ? RSP_STOP1 : RSP_PARITY;
                    end else if (txEnd) begin
                        txd <= txShift[0];
                        txParAcc <= txParAcc ^ txShift[0];
                        txShift <= txShift >> 1;
                        txBitCnt <= txBitCnt + 4'h1;
                    end
                end
                RSP_PARITY: begin
                    if (txEnd) begin
                        txd <= 1'b1;
                        txState <= RSP_STOP1;
                    end
                end
                // [R14] two stop bits
                RSP_STOP1: begin
                    if (txEnd) begin
                        txState <= RSP_STOP2;
                    end
                end
                RSP_STOP2: begin
                    if (txEnd) begin
                        txState <= RSP_IDLE;
                    end
                end
                default: begin
                    txState <= RSP_IDLE;
                    txd <= 1'b1;
                end
            endcase
        end
    end

    // Receive start edge realigns the bit timer
    assign rxStartEdge = rxState == RSP_IDLE && rxdLast && !rxdSync && ifaceSerial;

    rsp_bit_timer rxTimer (
        .clk(clk),
        .rst_n(rst_n),
        .divisor(divisor),
        .restart(rxStartEdge),
        .midTick(rxMid),
        .endTick(rxEnd)
    );

    // A 7-bit character lands one place high in the shifter
    assign rxByte = (parity == RSP_PAR_NONE) ? rxShift : {1'b0, rxShift[7:1]};
    assign rxPush = rxState == RSP_STOP2 && rxMid;

    // Receive frame sequencer, sampling at bit centres
    // [R23] centre sampling
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxState <= RSP_IDLE;
            rxShift <= 8'h00;
            rxBitCnt <= 4'h0;
            rxParAcc <= 1'b0;
        end else begin
            unique case (rxState)
                RSP_IDLE: begin
                    if (rxStartEdge) begin
                        rxState <= RSP_START;
                    end
                end
                RSP_START: begin
                    if (rxMid) begin
                        rxState <= rxdSync ? RSP_IDLE : RSP_DATA;
                        rxBitCnt <= 4'h0;
                        rxParAcc <= parity == RSP_PAR_ODD;
                    end
                end
                RSP_DATA: begin
                    if (rxMid) begin
                        rxShift <= {rxdSync, rxShift[7:1]};
                        rxParAcc <= rxParAcc ^ rxdSync;
                        rxBitCnt <= rxBitCnt + 4'h1;
                        if (rxBitCnt == dataBits - 4'h1) begin
                            rxState <= (parity == RSP_PAR_NONE) ? RSP_STOP1 : RSP_PARITY;
                        end
                    end
                end
                RSP_PARITY: begin
                    if (rxMid) begin
                        rxState <= RSP_STOP1;
                    end
                end
                RSP_STOP1: begin
                    if (rxMid) begin
                        rxState <= RSP_STOP2;
                    end
                end
                RSP_STOP2: begin
                    if (rxMid) begin
                        rxState <= RSP_IDLE;
                    end
                end
                default: begin
                    rxState <= RSP_IDLE;
                end
            endcase
        end
    end

    // Error flags; a new error wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frameErr <= 1'b0;
            parErr <= 1'b0;
            overrun <= 1'b0;
        end else begin
            if (accept && write && address == ADDR_STATUS && byteenable[1]) begin
                frameErr <= frameErr && !writedata[ST_FRAMEERR];
                parErr <= parErr && !writedata[ST_PARERR];
                overrun <= overrun && !writedata[ST_OVERRUN];
            end
            // [R23] stop bits must be high
            if ((rxState == RSP_STOP1 || rxState == RSP_STOP2) && rxMid && !rxdSync) begin
                frameErr <= 1'b1;
            end
            // [R22] parity check
            if (rxState == RSP_PARITY && rxMid && (rxParAcc ^ rxdSync)) begin
                parErr <= 1'b1;
            end
            if (rxPush && rxCount == 8'(RX_DEPTH)) begin
                overrun <= 1'b1;
            end
        end
    end

    // Receive buffer; remote clear empties it
    always_ff @(posedge clk) begin
        if (rxPush && rxCount != 8'(RX_DEPTH)) begin
            rxMem[rxWrPtr] <= rxByte;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || remoteClear) begin
            rxWrPtr <= '0;
            rxRdPtr <= '0;
            rxCount <= 8'h00;
        end else begin
            if (rxPush && rxCount != 8'(RX_DEPTH)) begin
                rxWrPtr <= rxWrPtr + 7'h1;
            end
            if (rxPop) begin
                rxRdPtr <= rxRdPtr + 7'h1;
            end
            rxCount <= rxCount + 8'(rxPush && rxCount != 8'(RX_DEPTH)) - 8'(rxPop);
        end
    end

    // Response bookkeeping: firmware marks a pending reply and its last byte
    assign respDone = respLast && !txFull && txState == RSP_IDLE;

    always_ff @(posedge clk) begin
        if (!rst_n || remoteClear) begin
            respPending <= 1'b0;
            respLast <= 1'b0;
            newlineSeen <= 1'b0;
        end else begin
            if (respDone) begin
                respPending <= 1'b0;
                respLast <= 1'b0;
                newlineSeen <= 1'b0;
            end
            if (accept && write && address == ADDR_CTRL && byteenable[0]) begin
                respPending <= respPending || writedata[CTRL_RESP_PEND];
                respLast <= respLast || writedata[CTRL_RESP_LAST];
            end
            if (rxPush && rxByte == NEWLINE_CHAR) begin
                newlineSeen <= 1'b1;
            end
        end
    end

    // [R16] terminal ready output
    // [R18] hold off near full
    // [R21] hold off while replying
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dtr <= 1'b0;
        end else begin
            dtr <= ifaceSerial && rxCount < RX_HIGH_WATER && !(respPending && newlineSeen);
        end
    end

    sequence s_last_data;
        txState == RSP_DATA && txEnd && txBitCnt == dataBits;
    endsequence

    sequence s_load;
        txLoad;
    endsequence

    AST_ONE_IFACE: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
        busEnable != serialEnable) else $error("both or no interfaces enabled");
    AST_DEFAULTS: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
        $rose(rst_n) |-> !ifaceSerial && busAddr == DEF_BUS_ADDR
            && baudSel == DEF_BAUD_SEL && parity == RSP_PAR_NONE)
        else $error("factory defaults wrong after reset");
    AST_ADDR_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
        busAddr <= BUS_ADDR_MAX) else $error("bus address above 30");
    AST_BAUD_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
        baudSel <= BAUD_SEL_MAX) else $error("illegal baud select");
    AST_CFG_KEEP: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        remoteClear && !cfgWe |=> $stable({ifaceSerial, busAddr, baudSel, parity}))
        else $error("remote clear altered settings");
    AST_START_BIT: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
        s_load |=> txState == RSP_START && !txd) else $error("start bit missing");
    AST_STOP_BITS: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
        txState == RSP_STOP1 && txEnd |=> txState == RSP_STOP2 && txd)
        else $error("second stop bit missing");
    AST_FRAME_ORDER: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
        s_last_data |=> txState == ((parity == RSP_PAR_NONE) ? RSP_STOP1 : RSP_PARITY))
        else $error("frame order broken");
    AST_DTR_FULL: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
        rxCount >= RX_HIGH_WATER |=> !dtr) else $error("DTR true with full buffer");
    AST_DSR_GATE: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
        txState == RSP_IDLE && !dsrSync |=> txState == RSP_IDLE)
        else $error("character started with DSR false");
    AST_DTR_RESP: assert property (@(posedge clk) disable iff (!rst_n) // [R21]
        respPending && newlineSeen |=> !dtr) else $error("DTR true during reply");
endmodule : rsp_serial_port

// *** verification/rsp_host_model.sv ***
`timescale 1ns/1ps
// Host end of the serial line, decodes and sends whole frames
module rsp_host_model (
    // Clock
    input wire logic clk,
    // Serial pins seen from the host
    input wire logic txd,
    input wire logic dtr,
    output logic rxd,
    output logic dsr
);
    int div = 10;
    int par = 0;
    int nRx = 0;
    int lateCnt = 0;
    logic [7:0] got;
    logic frameOk;

    // Line idles at mark, host ready
    initial begin
        rxd = 1'b1;
        dsr = 1'b1;
    end

    always begin
        @(negedge txd);
        repeat (div / 2) @(posedge clk);
        frameOk = !txd;
        got = 8'h00;
        for (int i = 0; i < (par ? 7 : 8); i++) begin
            repeat (div) @(posedge clk);
            got[i] = txd;
        end
        if (par) begin
            repeat (div) @(posedge clk);
            frameOk &= (txd == (^got[6:0] ^ (par == 2)));
        end
        repeat (div) @(posedge clk);
        frameOk &= txd;
        repeat (div) @(posedge clk);
        frameOk &= txd;
        nRx++;
    end

    task automatic send(input logic [7:0] b);
        wait (dtr || lateCnt < 10);
        lateCnt = dtr ? 0 : lateCnt + 1;
        @(posedge clk);
        rxd <= 1'b0;
        repeat (div) @(posedge clk);
        for (int i = 0; i < (par ? 7 : 8); i++) begin
            rxd <= b[i];
            repeat (div) @(posedge clk);
        end
        if (par) begin
            rxd <= ^b[6:0] ^ (par == 2);
            repeat (div) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (2 * div) @(posedge clk);
    endtask : send
endmodule : rsp_host_model

// *** verification/remote_serial_port_config_test.sv ***
`timescale 1ns/1ps
module remote_serial_port_config_test;
    import rsp_pkg::*;
    logic clk, rst_n, read, write, remoteClear, rxd, txd, dtr, dsr;
    logic waitrequest, busEnable, serialEnable;
    logic [4:0] address, busAddrOut;
    logic [31:0] writedata, readdata, rd;
    int errTotal, nTests, n0;

    // Short clock figure keeps the slowest rate at 320 cycles a bit
    rsp_serial_port #(.CLK_HZ(96000)) i_rsp_serial_port (.clk(clk), .rst_n(rst_n),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
        .remoteClear(remoteClear), .busEnable(busEnable), .serialEnable(serialEnable),
        .busAddrOut(busAddrOut), .rxd(rxd), .txd(txd), .dtr(dtr), .dsr(dsr));
    rsp_host_model i_rsp_host_model (.clk(clk), .txd(txd), .dtr(dtr), .rxd(rxd), .dsr(dsr));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task giveVerdict;
        $display("mismatches %0d of %0d checks", errTotal, nTests);
        if (errTotal == 0 && nTests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : giveVerdict

    // Request held until waitrequest is seen low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task cfg(input logic [2:0] b, input logic [1:0] p);
        bus(1'b1, ADDR_CFG, {21'h0, p, b, 5'h1e, 1'b1});
        i_rsp_host_model.div = 96000 / BAUD_RATE[b];
        i_rsp_host_model.par = p;
    endtask : cfg

    task txChk(input logic [7:0] b, input logic [7:0] e);
        n0 = i_rsp_host_model.nRx;
        bus(1'b1, ADDR_TXDATA, {24'h0, b});
        while (i_rsp_host_model.nRx == n0) @(posedge clk);
        chk({i_rsp_host_model.frameOk, i_rsp_host_model.got}, {1'b1, e});
    endtask : txChk

    task pulseClear;
        remoteClear <= 1'b1;
        @(posedge clk);
        remoteClear <= 1'b0;
    endtask : pulseClear

    task tConfig;
        bus(1'b0, ADDR_CFG, 0);
        chk(rd, 32'h14a);
        chk({busEnable, serialEnable, busAddrOut, dtr}, 8'h8a);
        bus(1'b1, ADDR_CFG, 32'h7ff);
        bus(1'b0, ADDR_CFG, 0);
        chk(rd, 32'h14b);
        bus(1'b1, ADDR_CFG, 32'h17d);
        repeat (3) @(posedge clk);
        chk({busEnable, serialEnable, busAddrOut, dtr}, 8'h7d);
        pulseClear();
        bus(1'b0, ADDR_CFG, 0);
        chk(rd, 32'h17d);
        bus(1'b0, 5'h14, 0);
        chk(rd, 32'h0);
    endtask : tConfig

    task tRates;
        for (int r = 0; r < NUM_RATES; r++) begin
            cfg(r[2:0], 2'h0);
            txChk(8'h41 + r[7:0], 8'h41 + r[7:0]);
        end
    endtask : tRates

    task tParity;
        for (int p = 0; p < 3; p++) begin
            cfg(3'h5, p[1:0]);
            txChk(8'hb5, p ? 8'h35 : 8'hb5);
            i_rsp_host_model.send(8'hc3);
            repeat (20) @(posedge clk);
            bus(1'b0, ADDR_RXDATA, 0);
            chk(rd, p ? 32'h143 : 32'h1c3);
        end
        // Host sends even parity to an odd-parity port: error flagged, byte kept
        i_rsp_host_model.par = 1;
        i_rsp_host_model.send(8'h11);
        i_rsp_host_model.par = 2;
        repeat (20) @(posedge clk);
        bus(1'b0, ADDR_STATUS, 0);
        chk(rd[15:8], 8'h59);
        bus(1'b1, ADDR_STATUS, 32'h4000);
        bus(1'b0, ADDR_RXDATA, 0);
        chk(rd, 32'h111);
        bus(1'b0, ADDR_STATUS, 0);
        chk(rd[15:8], 8'h18);
    endtask : tParity

    task tDsr;
        n0 = i_rsp_host_model.nRx;
        i_rsp_host_model.dsr <= 1'b0;
        repeat (4) @(posedge clk);
        bus(1'b1, ADDR_TXDATA, 32'h5a);
        repeat (100) @(posedge clk);
        chk(i_rsp_host_model.nRx, n0);
        i_rsp_host_model.dsr <= 1'b1;
        while (i_rsp_host_model.nRx == n0) @(posedge clk);
        chk({i_rsp_host_model.frameOk, i_rsp_host_model.got}, 9'h15a);
    endtask : tDsr

    task tFillAndReply;
        cfg(3'h5, 2'h0);
        for (int i = 0; i < 100; i++)
            i_rsp_host_model.send(8'h20 + i[7:0]);
        repeat (20) @(posedge clk);
        chk(dtr, 1'b0);
        bus(1'b0, ADDR_STATUS, 0);
        chk(rd[7:0], 8'h64);
        bus(1'b0, ADDR_RXDATA, 0);
        chk(rd, 32'h120);
        repeat (3) @(posedge clk);
        chk(dtr, 1'b1);
        pulseClear();
        bus(1'b1, ADDR_CTRL, 32'h1);
        i_rsp_host_model.send(NEWLINE_CHAR);
        repeat (20) @(posedge clk);
        chk(dtr, 1'b0);
        n0 = i_rsp_host_model.nRx;
        bus(1'b1, ADDR_TXDATA, 32'h4f);
        bus(1'b1, ADDR_CTRL, 32'h2);
        chk(dtr, 1'b0);
        while (i_rsp_host_model.nRx == n0) @(posedge clk);
        repeat (20) @(posedge clk);
        chk(dtr, 1'b1);
    endtask : tFillAndReply

    // Reset, then the scenarios in turn
    initial begin
        {read, write, remoteClear, rst_n} = 4'h0;
        address = 5'h00;
        writedata = 32'h0;
        errTotal = 0;
        nTests = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        tConfig();
        tRates();
        tParity();
        tDsr();
        tFillAndReply();
        giveVerdict();
    end

    // Run needs about 20000 cycles; cut a hang well past that
    initial begin
        repeat (80000) @(posedge clk);
        errTotal++;
        giveVerdict();
    end
endmodule : remote_serial_port_config_test
